/* File: hw/qpp_map.svh */
// Offsets, widths and timing constants of the quad-phase pipeline timing block
`ifndef QPP_MAP_SVH
`define QPP_MAP_SVH
`define QPP_PC_W          13
`define QPP_IMPL_AW       10
`define QPP_INSN_W        14
`define QPP_DATA_W        8
`define QPP_DADDR_W       7
`define QPP_NV_AW         6
`define QPP_NV_DEPTH      64
`define QPP_RESET_VECTOR  13'h0000
`define QPP_IRQ_VECTOR    13'h0004
`define QPP_OSC_DIV       4
`endif

/* File: hw/qpp_phase_gen.sv */
// Four-phase generator dividing its oscillator step input by four
`timescale 1ns/1ps
`default_nettype none
module qpp_phase_gen (
    input  wire logic                  core_clk,
    input  wire logic                  hold,
    input  wire logic                  step,
    output var qpp_pkg::qpp_phase_t    phase_q
);
    qpp_pkg::qpp_phase_t phase_next;
    qpp_pkg::qpp_phase_t phase_d;

    // Phases follow in fixed order one to four
    always_comb begin
        unique case (phase_q)
            qpp_pkg::QPP_PH_ONE:   phase_next = qpp_pkg::QPP_PH_TWO;   // RQ1
            qpp_pkg::QPP_PH_TWO:   phase_next = qpp_pkg::QPP_PH_THREE;
            qpp_pkg::QPP_PH_THREE: phase_next = qpp_pkg::QPP_PH_FOUR;
            qpp_pkg::QPP_PH_FOUR:  phase_next = qpp_pkg::QPP_PH_ONE;
        endcase
    end

    // Move on only at an oscillator step; parked in phase four while held
    assign phase_d = hold ? qpp_pkg::QPP_PH_FOUR : (step ? phase_next : phase_q); // RQ14

    // Phase register
    always_ff @(posedge core_clk) begin
        phase_q <= phase_d;
    end
endmodule : qpp_phase_gen
`default_nettype wire

/* File: hw/qpp_pipeline.sv */
// Quad-phase timing generator and two-stage fetch/execute sequencer
// What this block does
// [RQ1] Divide the oscillator by four into phases one to four in fixed order.
// [RQ2] Increment the program counter once per instruction cycle, in phase one.
// [RQ3] Read program memory in the fetch cycle, capture the word in phase four.
// [RQ4] Load instruction register in phase one, decode and execute in phases two to four.
// [RQ5] Read data memory in phase two, write destination in phase four.
// [RQ6] Overlap next fetch with current execution; plain instructions take one cycle.
// [RQ7] Program counter changes cost two cycles; fetched word discarded, target refetched.
// [RQ8] In RC mode drive the oscillator output pin at one quarter rate.
// [RQ9] Low master clear holds reset for as long as it stays low.
// [RQ10] Program and data memories have separate buses usable in one cycle.
// [RQ11] Sixty-four bytes of nonvolatile storage reached only through a six-bit pointer.
// [RQ12] Fetch starts at address zero after reset; interrupts vector to four.
// [RQ13] Only the lowest 1K words exist; higher addresses wrap.
// [RQ14] Reset holds phases and pipeline idle; release starts at phase one fetch.
// [RQ15] First cycle after reset fetches only and executes nothing.
`timescale 1ns/1ps
`default_nettype none
`include "qpp_map.svh"
module qpp_pipeline #(
    parameter int PC_W   = `QPP_PC_W,
    parameter int IMPL_W = `QPP_IMPL_AW
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       osc_input_pin,
    input  wire logic                       master_clear_n,
    input  wire logic                       rc_mode,
    output logic                            osc_output_pin,
    output logic                            phase_one,
    output logic                            phase_two,
    output logic                            phase_three,
    output logic                            phase_four,
    output logic [IMPL_W-1:0]               pmem_addr,
    input  wire logic [`QPP_INSN_W-1:0]     pmem_rdata,
    output logic [`QPP_INSN_W-1:0]          insn_q,
    output logic                            insn_valid,
    input  wire logic                       exec_branch,
    input  wire logic [PC_W-1:0]            exec_target,
    input  wire logic                       irq_req,
    output logic                            irq_ack,
    output logic                            dmem_rd,
    output logic                            dmem_wr,
    input  wire logic                       nv_we,
    input  wire logic [`QPP_NV_AW-1:0]      nv_ptr,
    input  wire logic [`QPP_DATA_W-1:0]     nv_wdata,
    output logic [`QPP_DATA_W-1:0]          nv_rdata
);
    initial begin
        if (PC_W < IMPL_W || IMPL_W < 3) begin
            $error("qpp_pipeline: PC_W must cover IMPL_W and IMPL_W >= 3");
        end
    end

    // Synchronisers for the oscillator and master clear pins.
    // Both pins are asynchronous to core_clk, so nothing but the second stage
    // is read by logic. The price is latency: an oscillator rise is seen
    // about three core_clk edges late, and a master clear level likewise.
    // The oscillator must therefore stay at least four core_clk in each level,
    // otherwise an edge could be lost between the two stages and the phase
    // count would slip by one against the pin.
    logic [1:0] osc_sync_q;
    logic [1:0] master_clear_n_sync_q;
    logic       osc_prev_q;
    always_ff @(posedge core_clk) begin
        osc_sync_q  <= {osc_sync_q[0], osc_input_pin};
        master_clear_n_sync_q <= {master_clear_n_sync_q[0], master_clear_n};
        osc_prev_q  <= osc_sync_q[1];
    end

    // Reset held by the core reset or a low master clear
    wire hold_rst = rst | ~master_clear_n_sync_q[1]; // RQ9
    wire osc_rise = osc_sync_q[1] & ~osc_prev_q;

    // Phase generator steps on each oscillator rising edge
    qpp_pkg::qpp_phase_t phase_q;
    qpp_phase_gen u_phase (
        .core_clk (core_clk),
        .hold     (hold_rst),
        .step     (osc_rise),
        .phase_q  (phase_q)
    );

    // A phase step happens at the edge that sees a synchronised oscillator rise.
    // The generator moves on at that same edge, so hot_now is the phase that is
    // ending and hot_after the one that the registered strobes show next.
    wire ph_step = osc_rise & ~hold_rst; // RQ14

    // One-hot view of a phase, shared by the entry decodes and the strobes
    function automatic logic [3:0] phase_hot(input qpp_pkg::qpp_phase_t ph);
        phase_hot = 4'h1 << ph;
    endfunction

    // Phase decodes: which phase ends, which one is entered at this edge
    wire logic [3:0] hot_now   = phase_hot(phase_q);
    wire logic [3:0] hot_after = ph_step ? {hot_now[2:0], hot_now[3]} : hot_now; // RQ1
    wire             is_p4     = hot_now[3];
    wire             ent_p1    = ph_step & hot_now[3];
    wire             ent_p2    = ph_step & hot_now[0];
    wire             ent_p4    = ph_step & hot_now[2];

    // Timing of one instruction word through the two stages:
    //   fetch cycle, phase one   : program counter steps to the word's address
    //   fetch cycle, phase four  : the word on pmem_rdata is captured
    //   exec cycle, phase one    : the word moves into insn_q
    //   exec cycle, phase two    : operand read strobe
    //   exec cycle, phase four   : destination write strobe
    // The fetch of the next word runs in the same cycle as this execute.
    // pmem_addr is registered, so it follows the counter one core_clk late;
    // with at least eight core_clk per phase the memory still has most of
    // phases one to three to answer before the capture in phase four.
    // A redirect is decided at the edge that leaves phase four: the word that
    // was prefetched meanwhile is loaded but marked not to execute, and the
    // fetch from the new target runs in the next cycle.

    // Pipeline state
    logic [PC_W-1:0]        pc_q;
    logic [`QPP_INSN_W-1:0] fetch_q;
    logic                   fetch_ok_q;
    logic                   exec_ok_q;
    logic                   started_q;

    // Wrap onto implemented program range
    function automatic logic [IMPL_W-1:0] wrap_addr(input logic [PC_W-1:0] a);
        wrap_addr = a[IMPL_W-1:0]; // RQ13
    endfunction

    wire take_branch = exec_ok_q & is_p4 & ph_step & exec_branch;
    wire take_irq    = is_p4 & ph_step & irq_req & ~take_branch;
    // Either redirect discards the word loaded at this same edge
    wire redirect    = take_branch | take_irq; // RQ7

    // Program counter: reset vector, increments each phase one except the first after reset, redirects in phase four
    always_ff @(posedge core_clk) begin
        if (hold_rst) begin
            pc_q      <= `QPP_RESET_VECTOR; // RQ12
            started_q <= 1'b0;
        end else if (take_branch) begin
            pc_q <= exec_target; // RQ7
        end else if (take_irq) begin
            pc_q <= `QPP_IRQ_VECTOR; // RQ12
        end else if (ent_p1 & started_q) begin
            pc_q <= pc_q + 1'b1; // RQ2
        end else if (ent_p1) begin
            started_q <= 1'b1;
        end
    end

    // Fetch latch in phase four, instruction register load in phase one
    always_ff @(posedge core_clk) begin
        if (hold_rst) begin
            fetch_q    <= '0;
            fetch_ok_q <= 1'b0;
            insn_q     <= '0;
            exec_ok_q  <= 1'b0; // RQ15
        end else begin
            if (ent_p4) begin
                fetch_q    <= pmem_rdata; // RQ3
                fetch_ok_q <= started_q;
            end
            if (ent_p1) begin
                insn_q    <= fetch_q; // RQ4
                exec_ok_q <= fetch_ok_q & ~redirect; // RQ6
            end
        end
    end

    // Nonvolatile bytes reached only through the pointer
    logic [`QPP_DATA_W-1:0] nv_mem [`QPP_NV_DEPTH];
    always_ff @(posedge core_clk) begin
        if (nv_we) begin
            nv_mem[nv_ptr] <= nv_wdata; // RQ11
        end
        nv_rdata <= nv_mem[nv_ptr];
    end

    // Quarter-rate clock output: high during phases one and two
    wire clkout_d = rc_mode & (hot_after[0] | hot_after[1]);

    // Registered outputs; data strobes from the execute slot on a separate bus
    always_ff @(posedge core_clk) begin
        if (hold_rst) begin
            osc_output_pin <= 1'b0;
            phase_one      <= 1'b0;
            phase_two      <= 1'b0;
            phase_three    <= 1'b0;
            phase_four     <= 1'b0;
            pmem_addr      <= '0;
            insn_valid     <= 1'b0;
            dmem_rd        <= 1'b0;
            dmem_wr        <= 1'b0;
            irq_ack        <= 1'b0;
        end else begin
            osc_output_pin <= clkout_d; // RQ8
            phase_one      <= hot_after[0]; // RQ1
            phase_two      <= hot_after[1];
            phase_three    <= hot_after[2];
            phase_four     <= hot_after[3];
            pmem_addr      <= wrap_addr(pc_q); // RQ10
            insn_valid     <= exec_ok_q;
            dmem_rd        <= exec_ok_q & ent_p2; // RQ5
            dmem_wr        <= exec_ok_q & ent_p4; // RQ5
            irq_ack        <= take_irq;
        end
    end
endmodule : qpp_pipeline
`default_nettype wire

/* File: hw/qpp_pkg.sv */
// Types shared by the quad-phase pipeline timing block
package qpp_pkg;
    typedef enum logic [1:0] {
        QPP_PH_ONE,
        QPP_PH_TWO,
        QPP_PH_THREE,
        QPP_PH_FOUR
    } qpp_phase_t;
endpackage : qpp_pkg

/* File: testbench/qpp_assertions.sv */
// Checker of quad-phase pipeline ports
`timescale 1ns/1ps
`default_nettype none
module qpp_chk #(parameter int IMPL_W = 10) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              master_clear_n,
    input wire logic              phase_one,
    input wire logic              phase_two,
    input wire logic              phase_three,
    input wire logic              phase_four,
    input wire logic [IMPL_W-1:0] pmem_addr,
    input wire logic [13:0]       insn_q,
    input wire logic              insn_valid,
    input wire logic              dmem_rd,
    input wire logic              dmem_wr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst || !master_clear_n);
    // Phase rotation, fetch and data strobes
    a_ph_onehot: assert property ($onehot0({phase_one, phase_two, phase_three, phase_four}))
        else $error("phases");
    a_ph_next: assert property ($fell(phase_one) |-> phase_two) else $error("q2");
    a_ph_mid: assert property ($fell(phase_two) |-> phase_three) else $error("q3");
    a_ph_wrap: assert property ($fell(phase_four) |-> phase_one) else $error("q1");
    a_pc_step: assert property ($changed(pmem_addr) |-> phase_one && !$past(phase_one, 2))
        else $error("pc");
    a_ir_load: assert property (!$rose(phase_one) |-> $stable(insn_q)) else $error("ir");
    a_rd_phase: assert property (dmem_rd |-> phase_two && insn_valid ##1 !dmem_rd)
        else $error("rd");
    a_wr_phase: assert property (dmem_wr |-> phase_four && insn_valid ##1 !dmem_wr)
        else $error("wr");
    c_write: cover property (dmem_wr);
    c_flush: cover property ($fell(insn_valid));
    c_exec: cover property ($rose(phase_one) && insn_valid);
endmodule // qpp_chk
`default_nettype wire

/* File: testbench/tb.sv */
// Bench of the quad-phase pipeline
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value t=%0t %h %h", $time, a, b); end end
module tb;
    logic        core_clk = 1'h0, rst = 1'h1, osc_input_pin = 1'h0, nv_we = 1'h1;
    logic        master_clear_n = 1'h1, rc_mode = 1'h1, exec_branch = 1'h0, irq_req = 1'h0;
    logic        osc_output_pin, phase_one, phase_two, phase_three, phase_four, insn_valid;
    logic        irq_ack, dmem_rd, dmem_wr;
    logic [12:0] exec_target = 13'h1C20;
    logic [5:0]  nv_ptr = 6'h3F;
    logic [7:0]  nv_wdata = 8'hC3, nv_rdata;
    logic [9:0]  pmem_addr;
    logic [13:0] insn_q;
    wire logic [13:0] pmem_rdata = {4'hA, pmem_addr};
    wire logic [3:0]  ph = {phase_four, phase_three, phase_two, phase_one};
    int          checks = 0, n_fail = 0, n_st = 0, n_irq = 0;
    qpp_pipeline uut (.*);
    // Clocks, strobe tally and run ceiling
    initial forever #2 core_clk = ~core_clk;
    always #16 osc_input_pin = ~osc_input_pin;
    always @(posedge core_clk) n_st += {dmem_wr, dmem_rd};
    always @(posedge core_clk) n_irq += irq_ack;
    initial begin
        repeat (2500) @(posedge core_clk);
        n_fail++;
        wrap_up;
    end
    // Wait for a rise of phase k, then one cycle more
    task automatic to_ph(input int k);
        for (int i = 0; i < 80 && ph[k]; i++) @(negedge core_clk);
        for (int i = 0; i < 80 && !ph[k]; i++) @(negedge core_clk);
        @(negedge core_clk);
    endtask
    // Fetch-only first cycle, then one word per cycle
    task automatic t_walk;
        to_ph(0);
        `CHK({insn_valid, pmem_addr, osc_output_pin}, {1'h0, 10'h000, 1'h1})
        to_ph(0);
        n_st = 0;
        `CHK({insn_valid, insn_q, pmem_addr}, {1'h1, 14'h2800, 10'h001})
        to_ph(0);
        `CHK({n_st[7:0], insn_q, pmem_addr}, {8'h03, 14'h2801, 10'h002})
    endtask
    // Branch, then interrupt, each flushing the prefetched word
    task automatic t_redirect;
        to_ph(3);
        exec_branch = 1'h1;
        to_ph(0);
        exec_branch = 1'h0;
        `CHK({insn_valid, pmem_addr}, {1'h0, 10'h020})
        to_ph(0);
        `CHK({insn_valid, insn_q, pmem_addr}, {1'h1, 14'h2820, 10'h021})
        irq_req = 1'h1;
        rc_mode = 1'h0;
        to_ph(0);
        irq_req = 1'h0;
        `CHK({insn_valid, pmem_addr, osc_output_pin, n_irq[3:0]}, {1'h0, 10'h004, 1'h0, 4'h1})
    endtask
    // Master clear idles the pipeline; the store keeps its byte
    task automatic t_master_clear_n;
        master_clear_n = 1'h0;
        repeat (8) @(negedge core_clk);
        `CHK({ph, pmem_addr, nv_rdata}, {4'h0, 10'h000, 8'hC3})
        master_clear_n = 1'h1;
        to_ph(0);
        `CHK({ph, insn_valid, pmem_addr}, {4'h1, 1'h0, 10'h000})
    endtask
    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'h0;
        nv_we = 1'h0;
        t_walk;
        t_redirect;
        t_master_clear_n;
        wrap_up;
    end
endmodule // tb
bind qpp_pipeline qpp_chk #(.IMPL_W(IMPL_W)) chk (.*);
`default_nettype wire
